// File: uart_rx_idle_overrun_noise_flags_test.sv
`timescale 1ns/100ps

// ==========================================================================
// bench for the receive flag block
// ==========================================================================
module uart_rx_idle_overrun_noise_flags_test
  import urf_pkg::*;
;
  localparam int BIT = 64; // divisor 3: 4 clocks a tick, 16 ticks a bit

  logic        ref_clk  = 1'h0;
  logic        reset_n  = 1'h0;
  logic        psel     = 1'h0;
  logic        penable  = 1'h0;
  logic        pwrite   = 1'h0;
  logic [7:0]  paddr    = 8'h00;
  logic [31:0] pwdata   = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        rxd;
  logic        irq;
  logic [31:0] q;
  logic        err;
  int          failures = 0;
  int          n_checks = 0;
  int          cyc      = 0;

  // clock and cycle count for delay measurement
  always #10 ref_clk = ~ref_clk;
  always @(posedge ref_clk) cyc <= cyc + 1;

  urf_rx_flags u_dut (
    .ref_clk(ref_clk), .reset_n(reset_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .rxd_pin(rxd), .irq(irq)
  );
  urf_line_model #(.BIT_CLKS(BIT)) u_line (.ref_clk(ref_clk), .rxd(rxd));

  // ==========================================================================
  // shared tasks
  // ==========================================================================
  task close_out;
    $display("checks %0d mismatches %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : close_out

  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  // one apb transfer; request held until ready is sampled high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge ref_clk);
    psel    <= 1'h1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge ref_clk);
    penable <= 1'h1;
    for (i = 0; i < 16; i++) begin
      @(posedge ref_clk);
      if (pready === 1'h1) break;
    end
    q       = prdata;
    err     = pslverr;
    psel    <= 1'h0;
    penable <= 1'h0;
    if (i == 16) begin
      failures++;
      close_out();
    end
  endtask : apb

  // polls status until a bit of m shows; the last poll is the clear-sequence read
  task automatic wait_st(input logic [31:0] m);
    int i;
    for (i = 0; i < 300; i++) begin
      apb(1'h0, URF_STATUS_OFS, 32'h0);
      if ((q & m) != 32'h0) return;
    end
    failures++;
    close_out();
  endtask : wait_st

  // ==========================================================================
  // scenarios
  // ==========================================================================
  task t_regs;
    apb(1'h0, URF_STATUS_OFS, 32'h0);
    chk("status after reset", q, 32'h0);
    apb(1'h1, URF_STATUS_OFS, 32'h3C);
    apb(1'h0, URF_STATUS_OFS, 32'h0);
    chk("status after write", q, 32'h0);
    apb(1'h0, URF_CTRL_OFS, 32'h0);
    chk("ctrl reset", q, {29'h0, URF_CTRL_RST});
    apb(1'h0, URF_BAUD_OFS, 32'h0);
    chk("baud reset", q, {16'h0, URF_BAUD_RST});
    apb(1'h0, 8'h40, 32'h0);
    chk("unmapped error", {31'h0, err}, 32'h1);
    apb(1'h1, URF_BAUD_OFS, 32'h3);
    $display("done regs");
  endtask : t_regs

  // all-ones char: counted from the start bit, or ten bit times after the stop bit
  task automatic t_idle(input logic after_stop);
    int   d;
    int   t0;
    logic ok;
    apb(1'h1, URF_CTRL_OFS, {29'h0, 2'h2, after_stop});
    u_line.send(9'h0FF, 8, -1);
    t0 = cyc;
    wait_st(32'h10);
    d = cyc - t0;
    ok = after_stop ? (d >= 9 * BIT && d <= 11 * BIT) : (d < 2 * BIT);
    chk("clean char flags", q & 32'h24, 32'h20);
    chk("idle delay", {31'h0, ok}, 32'h1);
    apb(1'h0, URF_DATA_OFS, 32'h0);
    chk("idle char", q, 32'hFF);
    apb(1'h0, URF_STATUS_OFS, 32'h0);
    chk("idle cleared", q & 32'h3C, 32'h0);
    repeat (20 * BIT) @(posedge ref_clk);
    apb(1'h0, URF_STATUS_OFS, 32'h0);
    chk("idle stays clear", q & 32'h10, 32'h0);
    $display("done idle %0d", after_stop);
  endtask : t_idle

  // second char is noisy and arrives unread; it and its noise must vanish
  task t_overrun;
    u_line.send(9'h012, 8, -1);
    u_line.send(9'h034, 8, 3);
    wait_st(32'h08);
    chk("overrun flags", q & 32'h2C, 32'h28);
    apb(1'h0, URF_DATA_OFS, 32'h0);
    chk("kept char", q, 32'h12);
    apb(1'h0, URF_STATUS_OFS, 32'h0);
    chk("overrun cleared", q & 32'h2C, 32'h0);
    $display("done overrun");
  endtask : t_overrun

  task t_noise;
    apb(1'h1, URF_IRQ_MASK_OFS, 32'h0);
    apb(1'h0, URF_IRQ_STAT_OFS, 32'h0);
    u_line.send(9'h0A5, 8, 3);
    wait_st(32'h20);
    chk("noise with full", q & 32'h24, 32'h24);
    chk("irq masked", {31'h0, irq}, 32'h0);
    apb(1'h1, URF_IRQ_MASK_OFS, 32'h8);
    repeat (3) @(posedge ref_clk);
    chk("irq raised", {31'h0, irq}, 32'h1);
    apb(1'h0, URF_IRQ_STAT_OFS, 32'h0);
    chk("irq cause", q & 32'h8, 32'h8);
    repeat (3) @(posedge ref_clk);
    chk("irq cleared", {31'h0, irq}, 32'h0);
    apb(1'h0, URF_DATA_OFS, 32'h0);
    chk("noisy char", q, 32'hA5);
    apb(1'h0, URF_STATUS_OFS, 32'h0);
    chk("noise cleared", q & 32'h24, 32'h0);
    $display("done noise");
  endtask : t_noise

  // nine-bit frames: top bit kept; a low top bit leaves ten idle bits after stop
  task automatic t_nine;
    int d;
    int t0;
    apb(1'h1, URF_CTRL_OFS, 32'h6);
    u_line.send(9'h0FF, 9, -1);
    t0 = cyc;
    wait_st(32'h10);
    d = cyc - t0;
    // a ten-bit target would show up near 9 * BIT, well under 600
    chk("nine idle delay", {31'h0, d > 600 && d < 11 * BIT}, 32'h1);
    apb(1'h0, URF_DATA_OFS, 32'h0);
    chk("nine char", q, 32'hFF);
    u_line.send(9'h155, 9, -1);
    wait_st(32'h20);
    apb(1'h0, URF_DATA_OFS, 32'h0);
    chk("nine top bit", q, 32'h155);
    $display("done nine");
  endtask : t_nine

  // ==========================================================================
  // main sequence
  // ==========================================================================
  initial begin
    repeat (8) @(posedge ref_clk);
    reset_n <= 1'h1;
    t_regs();
    t_idle(1'h0);
    t_idle(1'h1);
    t_overrun();
    t_noise();
    t_nine();
    close_out();
  end
endmodule : uart_rx_idle_overrun_noise_flags_test

// File: urf_line_model.sv
`timescale 1ns/100ps

// ==========================================================================
// remote transmitter: idle high, start, data lsb first, one stop
// ==========================================================================
module urf_line_model #(
  parameter int BIT_CLKS = 64
) (
  // clock
  input  wire logic ref_clk,
  // serial line
  output logic      rxd
);
  initial rxd = 1'h1;

  // glitch names a bit slot; one tick inverted mid-bit hits one sample only
  task automatic send(input logic [8:0] d, input int nb, input int glitch);
    int   b;
    int   c;
    logic v;
    for (b = 0; b < nb + 2; b++) begin
      v = (b == 0) ? 1'h0 : (b == nb + 1) ? 1'h1 : d[b - 1];
      for (c = 0; c < BIT_CLKS; c++) begin
        @(posedge ref_clk);
        rxd <= (b == glitch && c >= 38 && c < 42) ? ~v : v;
      end
    end
  endtask : send
endmodule : urf_line_model

// File: urf_pkg.sv
package urf_pkg;

  // ==========================================================================
  // register map (byte addresses on the apb word bus)
  // ==========================================================================
  localparam logic [7:0] URF_STATUS_OFS   = 8'h00; // serial_status_one
  localparam logic [7:0] URF_DATA_OFS     = 8'h04; // serial_data_reg
  localparam logic [7:0] URF_CTRL_OFS     = 8'h08;
  localparam logic [7:0] URF_BAUD_OFS     = 8'h0C;
  localparam logic [7:0] URF_IRQ_STAT_OFS = 8'h10;
  localparam logic [7:0] URF_IRQ_MASK_OFS = 8'h14;

  // ==========================================================================
  // field positions
  // ==========================================================================
  localparam int URF_FULL_BIT  = 5;
  localparam int URF_IDLE_BIT  = 4;
  localparam int URF_OVR_BIT   = 3;
  localparam int URF_NOISE_BIT = 2;
  localparam int URF_CTRL_AFT_BIT  = 0; // idle_count_after_stop_select
  localparam int URF_CTRL_NINE_BIT = 1; // nine_bit_char_select
  localparam int URF_CTRL_EN_BIT   = 2; // receiver enable
  localparam int URF_IRQ_FULL_BIT  = 0;
  localparam int URF_IRQ_IDLE_BIT  = 1;
  localparam int URF_IRQ_OVR_BIT   = 2;
  localparam int URF_IRQ_NOISE_BIT = 3;

  // ==========================================================================
  // reset values
  // ==========================================================================
  localparam logic [2:0]  URF_CTRL_RST     = 3'h4;    // enabled, 8 bit, idle from start bit
  localparam logic [15:0] URF_BAUD_RST     = 16'h001A; // 50 MHz / 27 = ~16 x 115200
  localparam logic [3:0]  URF_IRQ_MASK_RST = 4'h0;

  // ==========================================================================
  // timing counts, in oversample ticks, and last data bit indices
  // ==========================================================================
  localparam logic [3:0] URF_TICKS_LAST   = 4'hF;  // 16 ticks per bit
  localparam logic [3:0] URF_START_SMP_LO = 4'h4;  // seven start samples 4..10
  localparam logic [3:0] URF_BIT_SMP_LO   = 4'h8;  // three bit samples 8..10
  localparam logic [3:0] URF_SMP_HI       = 4'hA;
  localparam logic [7:0] URF_IDLE_TGT_8   = 8'hA0; // 10 bit times x 16
  localparam logic [7:0] URF_IDLE_TGT_9   = 8'hB0; // 11 bit times x 16
  localparam logic [3:0] URF_DBITS_8      = 4'h7;  // last data index, 8 bits
  localparam logic [3:0] URF_DBITS_9      = 4'h8;  // last data index, 9 bits

  // ==========================================================================
  // types
  // ==========================================================================
  typedef enum logic [1:0] {URF_HUNT, URF_START, URF_DATA, URF_STOP} urf_rx_state_e;

  typedef struct packed {
    logic full;
    logic idle;
    logic ovr;
    logic noise;
  } urf_flags_s;

  typedef struct packed {
    logic en;
    logic nine;
    logic after_stop;
  } urf_ctrl_s;

endpackage : urf_pkg

// File: urf_rx_flags.sv
// Decided for this implementation: the placing of the registers and the APB register port.
`timescale 1ns/100ps

module urf_rx_flags
  import urf_pkg::*;
(
  // clock and reset
  input  wire logic        ref_clk,
  input  wire logic        reset_n,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // serial line
  input  wire logic        rxd_pin,
  // interrupt
  output logic             irq
);

  // ==========================================================================
  // declarations
  // ==========================================================================
  logic          rxd_meta;
  logic          rxd_sync;
  logic          ack;
  logic          acc_done;
  logic          rd_status;
  logic          rd_data;
  logic          wr_en;
  logic          addr_ok;
  logic          tick;
  urf_ctrl_s     ctrl;
  logic [15:0]   baud_div;
  logic [3:0]    irq_mask;
  logic [3:0]    irq_stat;
  urf_flags_s    flags;
  urf_flags_s    seen;
  logic          seq_armed;
  logic [8:0]    data_buf;
  logic [8:0]    shift;
  urf_rx_state_e state;
  logic [3:0]    tick_cnt;
  logic [3:0]    bit_idx;
  logic [6:0]    smp;
  logic          frame_noise;
  logic          bit_val;
  logic          bit_noisy;
  logic          start_noisy;
  logic          in_window;
  logic          char_done;
  logic          load_ok;
  logic          ovr_evt;
  logic          idle_evt;
  logic [7:0]    idle_cnt;
  logic [7:0]    idle_tgt;
  logic          idle_hold;
  logic          idle_armed;
  logic [31:0]   next_rdata;

  // ==========================================================================
  // pin synchroniser
  // ==========================================================================
  // second stage is the only reader of the first
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      rxd_meta <= 1'b1;
      rxd_sync <= 1'b1;
    end else begin
      rxd_meta <= rxd_pin;
      rxd_sync <= rxd_meta;
    end
  end

  // ==========================================================================
  // apb slave: one wait state so read data comes from a flop
  // ==========================================================================
  assign addr_ok = (paddr == URF_STATUS_OFS) || (paddr == URF_DATA_OFS) ||
                   (paddr == URF_CTRL_OFS) || (paddr == URF_BAUD_OFS) ||
                   (paddr == URF_IRQ_STAT_OFS) || (paddr == URF_IRQ_MASK_OFS);
  assign pready    = ack;
  assign pslverr   = ack & ~addr_ok;
  assign acc_done  = psel & penable & ack;
  assign rd_status = acc_done & ~pwrite & (paddr == URF_STATUS_OFS);
  assign rd_data   = acc_done & ~pwrite & (paddr == URF_DATA_OFS);
  assign wr_en     = acc_done & pwrite;

  // ack rises in the second access cycle, falls with the transfer end
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      ack <= 1'b0;
    end else begin
      ack <= psel & penable & ~ack;
    end
  end

  // read mux, captured in the first access cycle
  always_comb begin
    next_rdata = 32'h0000_0000;
    case (paddr)
      URF_STATUS_OFS: begin
        next_rdata[URF_FULL_BIT]  = flags.full;
        next_rdata[URF_IDLE_BIT]  = flags.idle;
        next_rdata[URF_OVR_BIT]   = flags.ovr;
        next_rdata[URF_NOISE_BIT] = flags.noise;
      end
      URF_DATA_OFS:     next_rdata[8:0]  = data_buf;
      URF_CTRL_OFS:     next_rdata[2:0]  = ctrl;
      URF_BAUD_OFS:     next_rdata[15:0] = baud_div;
      URF_IRQ_STAT_OFS: next_rdata[3:0]  = irq_stat;
      URF_IRQ_MASK_OFS: next_rdata[3:0]  = irq_mask;
      default:          next_rdata       = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      prdata <= 32'h0000_0000;
    end else if (psel && penable && !ack && !pwrite) begin
      prdata <= next_rdata;
    end
  end

  // ==========================================================================
  // software-written registers; status bits have no write path
  // ==========================================================================
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      ctrl     <= URF_CTRL_RST;
      baud_div <= URF_BAUD_RST;
      irq_mask <= URF_IRQ_MASK_RST;
    end else if (wr_en) begin
      case (paddr)
        URF_CTRL_OFS: begin
          ctrl.after_stop <= pwdata[URF_CTRL_AFT_BIT];
          ctrl.nine <= pwdata[URF_CTRL_NINE_BIT];
          ctrl.en   <= pwdata[URF_CTRL_EN_BIT];
        end
        URF_BAUD_OFS:     baud_div <= pwdata[15:0];
        URF_IRQ_MASK_OFS: irq_mask <= pwdata[3:0];
        default:          ; // status and data writes are ignored
      endcase
    end
  end

  // ==========================================================================
  // oversample enable
  // ==========================================================================
  urf_tick_gen u_tick (
    .ref_clk (ref_clk),
    .reset_n (reset_n),
    .run     (ctrl.en),
    .divisor (baud_div),
    .tick    (tick)
  );

  // ==========================================================================
  // receive state machine
  // ==========================================================================
  // start bit window is wider so that seven samples fit
  assign in_window = (state == URF_START) ?
                     (tick_cnt >= URF_START_SMP_LO && tick_cnt <= URF_SMP_HI) :
                     (tick_cnt >= URF_BIT_SMP_LO && tick_cnt <= URF_SMP_HI);

  // majority of the last three samples decides the bit
  assign bit_val     = (smp[0] & smp[1]) | (smp[0] & smp[2]) | (smp[1] & smp[2]);
  assign bit_noisy   = ~((smp[2:0] == 3'b000) || (smp[2:0] == 3'b111));
  assign start_noisy = ~((smp == 7'h00) || (smp == 7'h7F));
  assign char_done   = tick && (state == URF_STOP) && (tick_cnt == URF_TICKS_LAST);

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      state       <= URF_HUNT;
      tick_cnt    <= 4'h0;
      bit_idx     <= 4'h0;
      smp         <= 7'h00;
      shift       <= 9'h000;
      frame_noise <= 1'b0;
    end else if (!ctrl.en) begin
      state <= URF_HUNT;
    end else if (tick) begin
      tick_cnt <= tick_cnt + 4'h1;
      if (state != URF_HUNT && in_window) begin
        smp <= {smp[5:0], rxd_sync};
      end
      unique case (state)
        URF_HUNT: begin
          // falling edge counts as tick 0 of the start bit
          tick_cnt <= 4'h1;
          if (!rxd_sync) begin
            state       <= URF_START;
            frame_noise <= 1'b0;
            smp         <= 7'h00;
          end
        end
        URF_START: begin
          if (tick_cnt == URF_TICKS_LAST) begin
            // a high majority is a glitch, not a start bit
            if (bit_val) begin
              state <= URF_HUNT;
            end else begin
              state       <= URF_DATA;
              bit_idx     <= 4'h0;
              frame_noise <= start_noisy;
            end
          end
        end
        URF_DATA: begin
          if (tick_cnt == URF_TICKS_LAST) begin
            shift       <= {bit_val, shift[8:1]};
            frame_noise <= frame_noise | bit_noisy;
            bit_idx     <= bit_idx + 4'h1;
            if (bit_idx == (ctrl.nine ? URF_DBITS_9 : URF_DBITS_8)) begin
              state <= URF_STOP;
            end
          end
        end
        URF_STOP: begin
          if (tick_cnt == URF_TICKS_LAST) begin
            frame_noise <= frame_noise | bit_noisy;
            state       <= URF_HUNT;
          end
        end
      endcase
    end
  end

  // ==========================================================================
  // buffer transfer and overrun
  // ==========================================================================
  // stop bit noise joins the frame here, as the last bit closes
  assign load_ok = char_done & ~flags.full;
  assign ovr_evt = char_done & flags.full;

  // on overrun the shifter content and its noise are simply dropped
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      data_buf <= 9'h000;
    end else if (load_ok) begin
      // eight-bit frames leave the character in the top of the shifter, nine fill it
      data_buf <= ctrl.nine ? shift : {1'b0, shift[8:1]};
    end
  end

  // ==========================================================================
  // idle line detection
  // ==========================================================================
  assign idle_tgt  = ctrl.nine ? URF_IDLE_TGT_9 : URF_IDLE_TGT_8;
  // after_stop holds the count for the whole frame, stop bit included
  assign idle_hold = (state == URF_START) || (ctrl.after_stop && state != URF_HUNT);
  assign idle_evt  = idle_armed && (idle_cnt >= idle_tgt) && !flags.idle;

  // high-line run length in oversample ticks, saturating at the target
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      idle_cnt <= 8'h00;
    end else if (tick) begin
      if (!rxd_sync || idle_hold) begin
        idle_cnt <= 8'h00;
      end else if (idle_cnt < idle_tgt) begin
        idle_cnt <= idle_cnt + 8'h01;
      end
    end
  end

  // armed by each character loaded into the buffer, spent by the idle it reports
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      idle_armed <= 1'b0;
    end else if (load_ok) begin
      idle_armed <= 1'b1;
    end else if (idle_evt) begin
      idle_armed <= 1'b0;
    end
  end

  // ==========================================================================
  // status flags and the read-status-then-read-data clear
  // ==========================================================================
  // remember which flags software saw set in the status read
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      seen      <= '0;
      seq_armed <= 1'b0;
    end else if (rd_status) begin
      seen      <= flags;
      seq_armed <= 1'b1;
    end else if (rd_data) begin
      seq_armed <= 1'b0;
    end
  end

  // clear first, then set, so a set in the clearing cycle wins
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      flags <= '0;
    end else begin
      if (rd_data && seq_armed) begin
        if (seen.full) begin
          flags.full <= 1'b0;
        end
        if (seen.idle) begin
          flags.idle <= 1'b0;
        end
        if (seen.ovr) begin
          flags.ovr <= 1'b0;
        end
        flags.noise <= 1'b0;
      end
      if (load_ok) begin
        flags.full  <= 1'b1;
        flags.noise <= frame_noise | bit_noisy;
      end
      if (ovr_evt) begin
        flags.ovr <= 1'b1;
      end
      if (idle_evt) begin
        flags.idle <= 1'b1;
      end
    end
  end

  // ==========================================================================
  // interrupt status, cleared by reading it; a new event wins
  // ==========================================================================
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      irq_stat <= 4'h0;
    end else begin
      if (acc_done && !pwrite && paddr == URF_IRQ_STAT_OFS) begin
        irq_stat <= 4'h0;
      end
      if (load_ok) begin
        irq_stat[URF_IRQ_FULL_BIT] <= 1'b1;
      end
      if (idle_evt) begin
        irq_stat[URF_IRQ_IDLE_BIT] <= 1'b1;
      end
      if (ovr_evt) begin
        irq_stat[URF_IRQ_OVR_BIT] <= 1'b1;
      end
      if (load_ok && (frame_noise || bit_noisy)) begin
        irq_stat[URF_IRQ_NOISE_BIT] <= 1'b1;
      end
    end
  end

  // level output, gated by the mask
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irq_stat & irq_mask);
    end
  end

endmodule : urf_rx_flags

// File: urf_rx_flags_chk.sv
`timescale 1ns/100ps

// ==========================================================================
// port-level checks for the receive flag block
// ==========================================================================
module urf_rx_flags_chk
  import urf_pkg::*;
(
  // clock and reset
  input wire logic        ref_clk,
  input wire logic        reset_n,
  // apb slave side
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // serial line and interrupt
  input wire logic        rxd_pin,
  input wire logic        irq
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);

  // answering edge of a status or data read
  wire logic st_rd = pready && !pwrite && paddr == URF_STATUS_OFS;
  wire logic dt_rd = pready && !pwrite && paddr == URF_DATA_OFS;

  // ==========================================================================
  // bus timing and responses
  // ==========================================================================
  a_ready_one_shot: assert property (pready |=> !pready)
    else $error("ready held longer than one cycle");
  a_one_wait_state: assert property ($rose(penable) && psel |-> !pready ##1 pready)
    else $error("answer not in second access cycle");
  a_err_map: assert property (pready && paddr[1:0] == 2'h0 |-> pslverr == (paddr > 8'h14))
    else $error("error response does not match the address map");
  a_err_with_ready: assert property (pslverr |-> pready)
    else $error("error response outside answering cycle");
  a_err_read_zero: assert property (pready && pslverr && !pwrite |-> prdata == 32'h0)
    else $error("refused read returned data");
  a_rdata_hold: assert property (!psel && $past(!psel) |-> $stable(prdata))
    else $error("read data moved while bus idle");
  a_irq_quiet_reset: assert property ($rose(reset_n) |-> !irq)
    else $error("interrupt high right after reset");

  // ==========================================================================
  // status and data contents
  // ==========================================================================
  a_status_spare_zero: assert property (st_rd |-> prdata[31:6] == 26'h0 && prdata[1:0] == 2'h0)
    else $error("status spare bits not zero");
  a_noise_needs_full: assert property (st_rd && prdata[2] |-> prdata[5])
    else $error("noise flag without buffer full");
  a_data_width: assert property (dt_rd |-> prdata[31:9] == 23'h0)
    else $error("data read upper bits not zero");

  // main scenarios seen
  c_idle: cover property (st_rd && prdata[4]);
  c_overrun: cover property (st_rd && prdata[3]);
  c_noise: cover property (st_rd && prdata[2]);
  c_irq: cover property (irq);
endmodule : urf_rx_flags_chk

bind urf_rx_flags urf_rx_flags_chk u_chk (
  .ref_clk(ref_clk), .reset_n(reset_n), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .rxd_pin(rxd_pin), .irq(irq)
);

// File: urf_tick_gen.sv
`timescale 1ns/100ps

// ==========================================================================
// oversample tick divider: one-cycle enable every (divisor + 1) clocks
// ==========================================================================
module urf_tick_gen
  import urf_pkg::*;
(
  // clock and reset
  input  wire logic        ref_clk,
  input  wire logic        reset_n,
  // control
  input  wire logic        run,
  input  wire logic [15:0] divisor,
  // enable out
  output logic             tick
);

  logic [15:0] div_cnt;

  // counter restarts whenever the receiver is disabled, so the phase is known
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      div_cnt <= 16'h0000;
      tick    <= 1'b0;
    end else if (!run) begin
      div_cnt <= 16'h0000;
      tick    <= 1'b0;
    end else if (div_cnt >= divisor) begin
      div_cnt <= 16'h0000;
      tick    <= 1'b1;
    end else begin
      div_cnt <= div_cnt + 16'h0001;
      tick    <= 1'b0;
    end
  end

endmodule : urf_tick_gen
